// ### inc/igca_pkg.sv
// Shared constants and carrier types of the general call and arbitration port
package igca_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int BUS_HALF_NS = 5000;
   localparam int HALF_CYC_INT = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] HALF_CYC = HALF_CYC_INT[7:0];

   // ************************************************************
   // Field positions and fixed values
   // ************************************************************
   localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
   localparam int RW_BIT = 0;
   localparam int MSB_BIT = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   typedef enum logic [3:0] {
      IGCA_IDLE, IGCA_S_ADDR, IGCA_S_DATA, IGCA_S_ACK, IGCA_S_SKIP,
      IGCA_M_START, IGCA_M_WAIT, IGCA_M_LOW, IGCA_M_HIGH, IGCA_M_STOP
   } igca_mode_t;

   // Configuration from the processor
   typedef struct packed {
      logic enable;
      logic generalCallEnable;
      logic tenBitMode;
      logic portIntEnable;
      logic sleepMode;
      logic [7:0] ownAddress;
   } igca_ctrl_t;

   // Status toward the processor
   typedef struct packed {
      logic startSeen;
      logic stopSeen;
      logic bufferFull;
      logic portEvent;
      logic collision;
      logic updateAddress;
      logic startPending;
      logic stopPending;
      logic wakeUp;
   } igca_status_t;

   typedef struct packed {
      igca_mode_t mode;
      logic sclMeta, sclSync, sclPrev;
      logic sdaMeta, sdaSync, sdaPrev;
      logic [7:0] shiftReg;
      logic [3:0] bitCnt;
      logic gcHit, nextData, sdaDrive, sclDrive;
      logic [7:0] divCnt;
      logic [1:0][7:0] rxMem;
      logic rxWr, rxRd;
      logic [1:0] rxCnt;
      logic [1:0][7:0] txMem;
      logic txWr, txRd;
      logic [1:0] txCnt;
      logic [7:0] txShift;
      logic [3:0] txBit;
      logic startSeen, stopSeen, portEvent, collision, updateAddress;
      logic startPending, stopPending, wakeUp;
   } igca_state_t;

endpackage : igca_pkg

// ### logic/igca_port.sv
// General call slave receiver and multi-master arbitrating transmitter
`timescale 1ns/10ps

// Overview of operation
// R1: All-zero address byte with write direction is the fixed general call address.
// R2: General call recognised only while general call enable is set.
// R3: After Start, shift eight bits; compare with own address and general call.
// R4: On match store byte, set buffer full; event flag at ninth falling edge.
// R5: Received address byte stays readable so software tells general call apart.
// R6: Ten-bit mode own-address match sets update address flag.
// R7: Ten-bit general call needs no second half, no update flag, data follows.
// R8: In sleep, matches and completed bytes wake processor if interrupt enabled.
// R9: Reset disables the port and ends any transfer.
// R10: Start-seen and stop-seen clear on reset and while disabled.
// R11: Master takes bus only when stop seen, or start and stop both clear.
// R12: With interrupt enabled, a Stop on the bus raises the event flag.
// R13: Hardware compares sampled SDA with driven level; mismatch sets collision.
// R14: Arbitration checked in address, data, Start, repeated Start and acknowledge; code checks only Start and the eight bits of each sent byte.
// R15: Released one sampled low while SCL high sets collision, port goes idle.
// R16: Collision in transmit halts, clears buffer full, releases lines, buffer writable.
// R17: Collision aborts Start or Stop, releases lines, clears their request bits.
// R18: After collision keep watching the bus; a Stop sets the event flag.
// R19: After collision a new data write starts from the first data bit.
// R20: Software resumes after a collision only on a free bus with a Start.
// R21: Acknowledge the general call on the ninth clock when enabled.
module igca_port
   import igca_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire igca_ctrl_t ctrl,
   input wire logic startReq,
   input wire logic stopReq,
   input wire logic eventClear,
   input wire logic collisionClear,
   input wire logic updateClear,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sclOut,
   output logic sclOe_n,
   output logic sdaOut,
   output logic sdaOe_n,
   input wire logic txValid,
   output logic txReady,
   input wire logic [7:0] txData,
   output logic rxValid,
   input wire logic rxReady,
   output logic [7:0] rxData,
   output igca_status_t status
);

   igca_state_t st;
   igca_state_t next_st;
   logic sclRise, sclFall, startCond, stopCond, busFree, masterMode;
   function automatic logic [1:0] igca_level(input logic [1:0] cnt, input logic dec,
                                             input logic inc);
      igca_level = cnt - {1'b0, dec} + {1'b0, inc};
   endfunction : igca_level

   // ************************************************************
   // Bus conditions seen through the synchronisers
   // ************************************************************
   assign sclRise = st.sclSync & ~st.sclPrev;
   assign sclFall = ~st.sclSync & st.sclPrev;
   assign startCond = st.sclSync & st.sclPrev & st.sdaPrev & ~st.sdaSync;
   assign stopCond = st.sclSync & st.sclPrev & ~st.sdaPrev & st.sdaSync;
   assign busFree = st.stopSeen | (~st.startSeen & ~st.stopSeen); // R11
   assign masterMode = st.mode inside {IGCA_M_START, IGCA_M_WAIT, IGCA_M_LOW,
                                       IGCA_M_HIGH, IGCA_M_STOP};

   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe_n = ~st.sclDrive;
   assign sdaOe_n = ~st.sdaDrive;
   assign txReady = st.txCnt != BUF_DEPTH;
   assign rxValid = st.rxCnt != 2'h0;
   assign rxData = st.rxMem[st.rxRd];

   always_comb begin
      logic pushRx, popTx, flushTx, setEvent, setColl, setUpd, ownHit, gcMatch;
      pushRx = 1'b0;
      popTx = 1'b0;
      flushTx = 1'b0;
      setEvent = 1'b0;
      setColl = 1'b0;
      setUpd = 1'b0;
      ownHit = st.shiftReg[7:1] == ctrl.ownAddress[7:1]; // R3
      gcMatch = ctrl.generalCallEnable && st.shiftReg == GEN_CALL_ADDR; // R1 R2 R3
      next_st = st;
      next_st.sclMeta = sclIn;
      next_st.sclSync = st.sclMeta;
      next_st.sclPrev = st.sclSync;
      next_st.sdaMeta = sdaIn;
      next_st.sdaSync = st.sdaMeta;
      next_st.sdaPrev = st.sdaSync;
      next_st.wakeUp = 1'b0;
      next_st.startPending = st.startPending | startReq;
      next_st.stopPending = st.stopPending | stopReq;

      // ************************************************************
      // Port sequencer
      // ************************************************************
      case (st.mode)
         IGCA_IDLE: begin
            if (st.startPending && busFree && st.sclSync && st.sdaSync) begin // R11
               next_st.mode = IGCA_M_START;
               next_st.sdaDrive = 1'b1;
               next_st.divCnt = HALF_CYC;
            end else if (st.startPending && busFree && !st.sdaSync) begin
               setColl = 1'b1; // R14
            end
         end
         IGCA_S_ADDR, IGCA_S_DATA: begin
            if (sclRise) begin
               next_st.shiftReg = {st.shiftReg[6:0], st.sdaSync}; // R3
               next_st.bitCnt = st.bitCnt + 4'h1;
            end else if (sclFall && st.bitCnt == BITS_PER_BYTE) begin
               // A full receive buffer is answered with no acknowledge, so nothing is lost
               if ((st.mode == IGCA_S_DATA || ownHit || gcMatch) && st.rxCnt != BUF_DEPTH) begin
                  pushRx = 1'b1; // R4 R5
                  next_st.sdaDrive = 1'b1; // R21
                  next_st.mode = IGCA_S_ACK;
                  next_st.wakeUp = ctrl.sleepMode && ctrl.portIntEnable; // R8
                  if (st.mode == IGCA_S_ADDR) begin
                     next_st.gcHit = gcMatch;
                     next_st.nextData = gcMatch || !st.shiftReg[RW_BIT];
                     setUpd = ctrl.tenBitMode && !gcMatch; // R6 R7
                  end
               end else begin
                  next_st.mode = IGCA_S_SKIP;
               end
            end
         end
         IGCA_S_ACK: begin
            if (sclFall) begin
               next_st.sdaDrive = 1'b0;
               setEvent = 1'b1; // R4
               next_st.bitCnt = 4'h0;
               next_st.mode = st.nextData ? IGCA_S_DATA : IGCA_S_SKIP; // R7
            end
         end
         IGCA_S_SKIP: begin
            next_st.sdaDrive = 1'b0;
         end
         IGCA_M_START: begin
            if (st.divCnt == 8'h00) begin
               next_st.sclDrive = 1'b1;
               next_st.startPending = 1'b0;
               next_st.mode = IGCA_M_WAIT;
            end else begin
               next_st.divCnt = st.divCnt - 8'h01;
            end
         end
         IGCA_M_WAIT: begin
            if (st.txCnt != 2'h0) begin
               popTx = 1'b1;
               next_st.txShift = st.txMem[st.txRd];
               next_st.txBit = 4'h0; // R19
               next_st.sdaDrive = ~st.txMem[st.txRd][MSB_BIT];
               next_st.divCnt = HALF_CYC;
               next_st.mode = IGCA_M_LOW;
            end else if (st.stopPending) begin
               next_st.sdaDrive = 1'b1;
               next_st.divCnt = HALF_CYC;
               next_st.mode = IGCA_M_STOP;
            end
         end
         IGCA_M_LOW: begin
            if (st.divCnt == 8'h00) begin
               next_st.sclDrive = 1'b0;
               next_st.divCnt = HALF_CYC;
               next_st.mode = IGCA_M_HIGH;
            end else begin
               next_st.divCnt = st.divCnt - 8'h01;
            end
         end
         IGCA_M_HIGH: begin
            // Counting waits for SCL to read high, so a stretching slave is honoured
            if (st.sclSync) begin
               if (!st.sdaDrive && !st.sdaSync && st.txBit != BITS_PER_BYTE) begin
                  setColl = 1'b1; // R13 R14 R15
               end else if (st.divCnt == 8'h00) begin
                  next_st.sclDrive = 1'b1;
                  next_st.divCnt = HALF_CYC;
                  if (st.txBit == BITS_PER_BYTE) begin
                     setEvent = 1'b1;
                     next_st.mode = IGCA_M_WAIT;
                  end else begin
                     next_st.txBit = st.txBit + 4'h1;
                     next_st.txShift = {st.txShift[6:0], 1'b0};
                     next_st.sdaDrive = (st.txBit == 4'h7) ? 1'b0 : ~st.txShift[6];
                     next_st.mode = IGCA_M_LOW;
                  end
               end else begin
                  next_st.divCnt = st.divCnt - 8'h01;
               end
            end
         end
         IGCA_M_STOP: begin
            if (st.sclDrive) begin
               if (st.divCnt == 8'h00) begin
                  next_st.sclDrive = 1'b0;
                  next_st.divCnt = HALF_CYC;
               end else begin
                  next_st.divCnt = st.divCnt - 8'h01;
               end
            end else if (st.sclSync) begin
               if (st.divCnt == 8'h00) begin
                  next_st.sdaDrive = 1'b0;
                  next_st.stopPending = 1'b0;
                  next_st.mode = IGCA_IDLE;
               end else begin
                  next_st.divCnt = st.divCnt - 8'h01;
               end
            end
         end
         default: begin
            next_st.mode = IGCA_IDLE;
         end
      endcase

      // Conditions on the wire; a slave follows any Start seen outside master mode unless that cycle flags a collision
      if (startCond) begin
         next_st.startSeen = 1'b1;
         next_st.stopSeen = 1'b0;
         if (!masterMode) begin
            next_st.mode = IGCA_S_ADDR; // R3
            next_st.bitCnt = 4'h0;
            next_st.sdaDrive = 1'b0;
         end
      end
      if (stopCond) begin
         next_st.startSeen = 1'b0;
         next_st.stopSeen = 1'b1;
         setEvent = setEvent | ctrl.portIntEnable | st.collision; // R12 R18
         if (!masterMode) begin
            next_st.mode = IGCA_IDLE;
            next_st.sdaDrive = 1'b0;
         end
      end
      if (setColl) begin
         flushTx = 1'b1; // R16
         next_st.mode = IGCA_IDLE; // R15
         next_st.sdaDrive = 1'b0; // R16 R17
         next_st.sclDrive = 1'b0;
         next_st.startPending = 1'b0; // R17
         next_st.stopPending = 1'b0;
         next_st.txBit = 4'h0; // R19
      end

      // ************************************************************
      // Two-entry buffers and sticky flags
      // ************************************************************
      if (pushRx) begin
         next_st.rxMem[st.rxWr] = st.shiftReg;
         next_st.rxWr = ~st.rxWr;
      end
      next_st.rxRd = st.rxRd ^ (rxValid && rxReady);
      next_st.rxCnt = igca_level(st.rxCnt, rxValid && rxReady, pushRx);
      if (flushTx) begin
         next_st.txRd = st.txWr;
      end else if (popTx) begin
         next_st.txRd = ~st.txRd;
      end
      if (txValid && txReady) begin
         next_st.txMem[st.txWr] = txData;
         next_st.txWr = ~st.txWr;
      end
      next_st.txCnt = igca_level(flushTx ? 2'h0 : st.txCnt, popTx && !flushTx,
                                 txValid && txReady);
      next_st.portEvent = (st.portEvent & ~eventClear) | setEvent;
      next_st.collision = (st.collision & ~collisionClear) | setColl;
      next_st.updateAddress = (st.updateAddress & ~updateClear) | setUpd;
      if (!ctrl.enable) begin
         next_st.mode = IGCA_IDLE; // R9
         next_st.sdaDrive = 1'b0;
         next_st.sclDrive = 1'b0;
         next_st.startSeen = 1'b0; // R10
         next_st.stopSeen = 1'b0;
         next_st.startPending = 1'b0;
         next_st.stopPending = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st <= '{mode: IGCA_IDLE, sclMeta: 1'b1, sclSync: 1'b1, sclPrev: 1'b1, sdaMeta: 1'b1,
                 sdaSync: 1'b1, sdaPrev: 1'b1, shiftReg: SHIFT_RESET, default: '0}; // R9 R10
      end else begin
         st <= next_st;
      end
   end

   assign status = '{startSeen: st.startSeen, stopSeen: st.stopSeen,
                     bufferFull: st.rxCnt != 2'h0 || st.txCnt != 2'h0,
                     portEvent: st.portEvent, collision: st.collision,
                     updateAddress: st.updateAddress, startPending: st.startPending,
                     stopPending: st.stopPending, wakeUp: st.wakeUp};

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   gc_enable_gate_a: assert property ($rose(st.gcHit) |-> $past(ctrl.generalCallEnable)) // R2
      else $error("general call taken while disabled");
   gc_ack_drive_a: assert property (st.mode == IGCA_S_ACK |-> st.sdaDrive && !sdaOe_n) // R21
      else $error("acknowledge not driven");
   ninth_event_a: assert property (st.mode == IGCA_S_ACK && sclFall |=> st.portEvent) // R4
      else $error("event flag missing after ninth bit");
   byte_stored_a: assert property ($rose(st.mode == IGCA_S_ACK) |-> status.bufferFull
      && st.rxMem[$past(st.rxWr)] == $past(st.shiftReg)) // R4
      else $error("received byte not stored");
   gc_no_update_a: assert property ($rose(st.updateAddress) |-> !st.gcHit
      && $past(ctrl.tenBitMode)) // R7
      else $error("update flag set for general call");
   collision_idle_a: assert property ($rose(st.collision) |-> st.mode == IGCA_IDLE
      && !st.sdaDrive && !st.sclDrive && st.txCnt <= 2'h1) // R15
      else $error("collision did not idle the port");
   collision_reqs_a: assert property ($rose(st.collision) |-> !st.startPending
      && !st.stopPending) // R17
      else $error("requests survived collision");
   stop_event_a: assert property (stopCond && ctrl.portIntEnable |=> st.portEvent) // R12
      else $error("stop did not raise event");
   disable_clear_a: assert property (!ctrl.enable |=> !st.startSeen && !st.stopSeen) // R10
      else $error("start or stop seen while disabled");
   master_free_a: assert property ($rose(st.mode == IGCA_M_START) |-> $past(busFree)) // R11
      else $error("bus taken while busy");
   wake_gate_a: assert property (st.wakeUp |-> $past(ctrl.sleepMode && ctrl.portIntEnable)) // R8
      else $error("wake without sleep and enable");

   gc_receive_c: cover property (st.gcHit && st.mode == IGCA_S_DATA);
   arb_lost_c: cover property ($rose(st.collision));
   master_stop_c: cover property (st.mode == IGCA_M_STOP ##1 st.mode == IGCA_IDLE);
   rx_full_c: cover property (st.rxCnt == BUF_DEPTH);
endmodule : igca_port

// ### test/igca_bus_model.sv
// Far-side bus party: second master, byte monitor and wired-and bus lines
`timescale 1ns/10ps
module igca_bus_model (
   input wire logic clk_sys,
   input wire logic sclOe_n,
   input wire logic sdaOe_n,
   output logic sclWire,
   output logic sdaWire,
   output logic [7:0] lastByte,
   output int byteCount
);
   logic sclDrv = 1'b0;
   logic sdaDrv = 1'b0;
   logic sclOld = 1'b1;
   logic sdaOld = 1'b1;
   logic [3:0] bitNum = 4'h0;
   logic [7:0] shiftIn = 8'h00;

   // Pull-ups on both wires: a released line reads high
   assign sclWire = ~(sclDrv | ~sclOe_n);
   assign sdaWire = ~(sdaDrv | ~sdaOe_n);

   initial begin
      lastByte = 8'h00;
      byteCount = 0;
   end

   // ************************************************************
   // Monitor: bytes sent by whoever masters the bus
   // ************************************************************
   always @(posedge clk_sys) begin
      sclOld <= sclWire;
      sdaOld <= sdaWire;
      if (sclWire && sclOld && sdaOld && !sdaWire) begin
         bitNum <= 4'h0;
      end else if (sclWire && !sclOld) begin
         if (bitNum == 4'h8) begin
            bitNum <= 4'h0;
         end else begin
            shiftIn <= {shiftIn[6:0], sdaWire};
            bitNum <= bitNum + 4'h1;
            if (bitNum == 4'h7) begin
               lastByte <= {shiftIn[6:0], sdaWire};
               byteCount <= byteCount + 1;
            end
         end
      end
   end

   // ************************************************************
   // Master tasks, 320 ns bit period (6 low, 2 high)
   // ************************************************************
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : step

   // Caller starts only on an idle bus
   task automatic sendStart();
      sdaDrv = 1'b1;
      step(4);
      sclDrv = 1'b1;
      step(2);
   endtask : sendStart

   // Long low phase leaves room for the slave to drop its acknowledge
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         step(5);
         sdaDrv = ~b[i];
         step(1);
         sclDrv = 1'b0;
         step(2);
         sclDrv = 1'b1;
      end
      step(5);
      sdaDrv = 1'b0;
      step(1);
      sclDrv = 1'b0;
      step(1);
      ack = ~sdaWire;
      step(1);
      sclDrv = 1'b1;
   endtask : sendByte

   task automatic sendStop();
      step(5);
      sdaDrv = 1'b1;
      step(1);
      sclDrv = 1'b0;
      step(4);
      sdaDrv = 1'b0;
      step(4);
   endtask : sendStop

   task automatic holdSda(input logic on);
      sdaDrv = on;
   endtask : holdSda
endmodule : igca_bus_model

// ### test/igca_port_tb.sv
// Bench: general call receive, buffers, arbitration loss and recovery
`timescale 1ns/10ps
module igca_port_tb
   import igca_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   igca_ctrl_t ctrl;
   igca_status_t status;
   logic startReq = 1'b0;
   logic stopReq = 1'b0;
   logic eventClear = 1'b0;
   logic collisionClear = 1'b0;
   logic updateClear = 1'b0;
   logic txValid = 1'b0;
   logic [7:0] txData = 8'h00;
   logic rxReady = 1'b0;
   logic sclOe_n, sdaOe_n, txReady, rxValid, sclWire, sdaWire, sclOut, sdaOut;
   logic [7:0] rxData, seenByte;
   logic wakeSeen = 1'b0;
   int seenCount, startCount;
   int fail_count = 0;
   int checks_done = 0;

   igca_port i_igca_port (.clk_sys(clk_sys), .reset_n(reset_n), .ctrl(ctrl),
      .startReq(startReq), .stopReq(stopReq), .eventClear(eventClear),
      .collisionClear(collisionClear), .updateClear(updateClear), .sclIn(sclWire),
      .sdaIn(sdaWire), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
      .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid),
      .rxReady(rxReady), .rxData(rxData), .status(status));
   igca_bus_model i_igca_bus_model (.clk_sys(clk_sys), .sclOe_n(sclOe_n),
      .sdaOe_n(sdaOe_n), .sclWire(sclWire), .sdaWire(sdaWire), .lastByte(seenByte),
      .byteCount(seenCount));

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   // Wake-up is a single-cycle pulse, so it is latched here
   always @(posedge clk_sys) begin
      if (status.wakeUp === 1'b1) begin
         wakeSeen <= 1'b1;
      end
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic summarize();
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask : check

   function automatic logic expAck(input logic [7:0] a);
      if (a == GEN_CALL_ADDR) begin
         return ctrl.generalCallEnable;
      end
      return a[7:1] == ctrl.ownAddress[7:1];
   endfunction : expAck

   function automatic logic flagOf(input int sel);
      case (sel)
         0: return ~sclOe_n;
         1: return status.collision;
         default: return seenCount != startCount;
      endcase
   endfunction : flagOf

   task automatic waitFlag(input int sel, input int lim);
      int n;
      n = 0;
      while (flagOf(sel) !== 1'b1 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= lim) begin
         $display("ERROR %0t wait ran out", $time);
         fail_count++;
         summarize();
      end
   endtask : waitFlag

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask : pulse

   task automatic popCheck(input logic [7:0] e);
      check(16'(rxValid), 16'h0001);
      check(16'(rxData), 16'(e));
      rxReady = 1'b1;
      @(negedge clk_sys);
      rxReady = 1'b0;
      @(negedge clk_sys);
   endtask : popCheck

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      logic ack;
      logic [7:0] d1, d2, b;
      void'($urandom(48));
      ctrl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {7'($urandom_range(8, 119)), 1'b0}};
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      b = 8'($urandom);
      repeat (3) @(negedge clk_sys);
      check(16'(status), 16'h0000);
      check(16'({sdaOe_n, sclOe_n, txReady, rxValid}), 16'h000E);
      check(16'({sclOut, sdaOut}), 16'h0000);
      reset_n = 1'b1;
      @(negedge clk_sys);
      // Ten-bit mode general call, receive side stalled until it refuses
      i_igca_bus_model.sendStart();
      i_igca_bus_model.sendByte(GEN_CALL_ADDR, ack);
      check(16'(ack), 16'(expAck(GEN_CALL_ADDR)));
      check(16'(status.bufferFull), 16'h0001);
      repeat (6) @(negedge clk_sys);
      check(16'(status.portEvent), 16'h0001);
      pulse(eventClear);
      i_igca_bus_model.sendByte(d1, ack);
      check(16'(ack), 16'h0001);
      i_igca_bus_model.sendByte(d2, ack);
      check(16'(ack), 16'h0000);
      check(16'(status.updateAddress), 16'h0000);
      pulse(eventClear);
      i_igca_bus_model.sendStop();
      repeat (4) @(negedge clk_sys);
      check(16'({status.stopSeen, status.portEvent}), 16'h0003);
      pulse(eventClear);
      popCheck(GEN_CALL_ADDR);
      popCheck(d1);
      check(16'({rxValid, status.bufferFull}), 16'h0000);
      // General call ignored while disabled
      ctrl.generalCallEnable = 1'b0;
      i_igca_bus_model.sendStart();
      i_igca_bus_model.sendByte(GEN_CALL_ADDR, ack);
      check(16'(ack), 16'(expAck(GEN_CALL_ADDR)));
      i_igca_bus_model.sendStop();
      check(16'(rxValid), 16'h0000);
      // Read address outside ten-bit mode: acknowledged, byte kept, no update flag
      ctrl.tenBitMode = 1'b0;
      i_igca_bus_model.sendStart();
      i_igca_bus_model.sendByte(ctrl.ownAddress | 8'h01, ack);
      check(16'({ack, status.updateAddress}), 16'({expAck(ctrl.ownAddress | 8'h01), 1'b0}));
      i_igca_bus_model.sendStop();
      popCheck(ctrl.ownAddress | 8'h01);
      ctrl.tenBitMode = 1'b1;
      ctrl.generalCallEnable = 1'b1;
      // Own address in sleep
      ctrl.sleepMode = 1'b1;
      wakeSeen = 1'b0;
      i_igca_bus_model.sendStart();
      i_igca_bus_model.sendByte(ctrl.ownAddress, ack);
      check(16'(ack), 16'(expAck(ctrl.ownAddress)));
      check(16'(status.updateAddress), 16'h0001);
      i_igca_bus_model.sendByte(d2, ack);
      i_igca_bus_model.sendStop();
      check(16'(wakeSeen), 16'h0001);
      popCheck(ctrl.ownAddress);
      popCheck(d2);
      pulse(updateClear);
      check(16'(status.updateAddress), 16'h0000);
      ctrl.sleepMode = 1'b0;
      ctrl.enable = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(16'({status.startSeen, status.stopSeen}), 16'h0000);
      ctrl.enable = 1'b1;
      // Transmit loses arbitration on a released one
      txValid = 1'b1;
      txData = 8'h80 | d1;
      @(negedge clk_sys);
      txData = d2;
      @(negedge clk_sys);
      txValid = 1'b0;
      check(16'(txReady), 16'h0000);
      pulse(startReq);
      waitFlag(0, 400);
      i_igca_bus_model.holdSda(1'b1);
      waitFlag(1, 1000);
      repeat (2) @(negedge clk_sys);
      check(16'({sdaOe_n, sclOe_n, status.startPending, status.bufferFull, txReady}),
         16'h0019);
      // Interrupt enable off, so only the collision flag can raise the event
      ctrl.portIntEnable = 1'b0;
      pulse(eventClear);
      i_igca_bus_model.sendStop();
      repeat (4) @(negedge clk_sys);
      check(16'({status.portEvent, status.collision}), 16'h0003);
      ctrl.portIntEnable = 1'b1;
      pulse(collisionClear);
      // Busy bus holds off the new Start; newly written byte starts at its first bit
      i_igca_bus_model.sendStart();
      txValid = 1'b1;
      txData = b;
      @(negedge clk_sys);
      txValid = 1'b0;
      pulse(startReq);
      repeat (200) @(negedge clk_sys);
      check(16'({sdaOe_n, status.startPending}), 16'h0003);
      startCount = seenCount;
      i_igca_bus_model.sendStop();
      pulse(stopReq);
      waitFlag(2, 4000);
      check(16'(seenByte), 16'(b));
      repeat (800) @(negedge clk_sys);
      check(16'({status.stopPending, status.stopSeen, sdaOe_n, sclOe_n}), 16'h0007);
      summarize();
   end
endmodule : igca_port_tb
